/* hw/bmc_error_status_bank.sv */
/*
 * Management error status bank: four sticky 8-bit fault registers,
 * sleep masking, read/write-one clearing, summary flag and alert.
 * Assumes fault inputs come from same-clock logic, except the two
 * low-active fuse pins, which are synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none

// How it works
// RULE_01: Inputs 1-8 window faults, masked S3/S4-5
// RULE_02: Inputs 9-16 faults, per-bit sleep masks
// RULE_03: Diode b-channel faults, optional sleep mask
// RULE_04: Diode a-channel faults, optional sleep mask
// RULE_05: Fuse pins flagged only in legacy mode
// RULE_06: Processor-1 core voltage mismatch sets bit 4
// RULE_07: Processor-2 core voltage mismatch sets bit 5
// RULE_08: Only over-limit throttle bit feeds summary
// RULE_09: Throttle any, six bins, over-limit bit
// RULE_10: Reset to zero, written zeros change nothing
// RULE_11: Summary flag from status bits, gated alert
// RULE_12: Sticky; live unmasked fault blocks clearing
// RULE_13: Special mode also clears on read
// RULE_14: Sleep state and optional masks steer masking
module bmc_error_status_bank
	import status_bank_pkg::*;
(
	// Clock, reset, enable
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic             ce,
	// Register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	input  wire logic [7:0]       reg_wdata,
	output logic      [7:0]       reg_rdata,
	// Mode and sleep controls
	input  wire logic             asf_mode,
	input  wire logic             alert_enable,
	input  wire logic             legacy_regulator_mode,
	input  wire logic [1:0]       sleep_state,
	input  wire logic [2:0]       hi_opt_mask_s3,
	input  wire logic [2:0]       hi_opt_mask_s45,
	input  wire logic [3:0]       diode_opt_mask_s3,
	input  wire logic [3:0]       diode_opt_mask_s45,
	// Fault sources
	input  wire logic [15:0]      window_fault,
	input  wire logic             diode1_chan_b_fault,
	input  wire logic             diode2_chan_b_fault,
	input  wire logic             diode1_chan_a_fault,
	input  wire logic             diode2_chan_a_fault,
	input  wire logic             fuse_monitor_in_a_n,
	input  wire logic             fuse_monitor_in_b_n,
	input  wire logic             cpu1_vcore_mismatch,
	input  wire logic             cpu2_vcore_mismatch,
	// Throttle measurement
	input  wire logic             throttle_valid,
	input  wire logic [THR_W-1:0] throttle_meas,
	input  wire logic [THR_W-1:0] throttle_user_limit,
	// Summary outputs
	output logic                  mgmt_error_summary,
	output logic                  alert_n
);

	// ==========================================================
	// Functions

	// Optional per-state mask
	function automatic logic [3:0] opt_mask(
		input logic [3:0] m_s3,
		input logic [3:0] m_s45,
		input logic       s3,
		input logic       s45
	);
		opt_mask = ({4{s3}} & m_s3) | ({4{s45}} & m_s45);
	endfunction : opt_mask

	// Clear strobes for one register offset
	function automatic logic [7:0] clr_for(
		input logic [7:0] ofs,
		input logic [7:0] addr,
		input logic       wr,
		input logic       rd,
		input logic       asf,
		input logic [7:0] wdata
	);
		clr_for = 8'h00;
		if (addr == ofs) begin
			if (wr) begin
				clr_for = wdata;
			end
			if (rd && asf) begin
				clr_for = 8'hFF;
			end
		end
	endfunction : clr_for

	// ==========================================================
	// State and wires
	typedef struct packed {
		logic [1:0] fuse_s1;
		logic [1:0] fuse_s2;
		logic [7:0] rdata;
		logic       summary;
		logic       alert_n;
	} bank_state_t;

	bank_state_t st_r;
	bank_state_t st_nxt;

	logic       in_s3;
	logic       in_s45;
	logic       deep;
	logic [7:0] mask_lo;
	logic [7:0] mask_hi;
	logic [7:0] mask_df;
	logic [7:0] mask_thr;
	logic [3:0] hi_opt;
	logic [3:0] df_opt;
	logic [7:0] raw_df;
	logic [7:0] evt_lo;
	logic [7:0] evt_hi;
	logic [7:0] evt_df;
	logic [7:0] evt_thr;
	logic [7:0] clr_lo;
	logic [7:0] clr_hi;
	logic [7:0] clr_df;
	logic [7:0] clr_thr;
	logic [7:0] stat_lo;
	logic [7:0] stat_hi;
	logic [7:0] stat_df;
	logic [7:0] stat_thr;
	logic [7:0] bin_evt;
	logic       summary_now;

	// ==========================================================
	// Sleep masking
	assign in_s3  = sleep_state == SLEEP_S3;              // RULE_14
	assign in_s45 = sleep_state == SLEEP_S45;             // RULE_14
	assign deep   = in_s3 | in_s45;

	assign hi_opt = opt_mask({1'b0, hi_opt_mask_s3},
		{1'b0, hi_opt_mask_s45}, in_s3, in_s45);          // RULE_14
	assign df_opt = opt_mask(diode_opt_mask_s3,
		diode_opt_mask_s45, in_s3, in_s45);               // RULE_14

	// Fixed and optional masks per register
	assign mask_lo  = {8{deep}};                          // RULE_01
	assign mask_hi  = {1'b0, deep, hi_opt[2:0],
		{3{deep}}};                                       // RULE_02
	assign mask_df  = {df_opt[3], df_opt[2], {4{deep}},
		df_opt[1], df_opt[0]};                            // RULE_03 RULE_04
	assign mask_thr = {8{deep}};

	// ==========================================================
	// Event sources
	always_comb begin
		raw_df = 8'h00;
		raw_df[BIT_D1B] = diode1_chan_b_fault;            // RULE_03
		raw_df[BIT_D2B] = diode2_chan_b_fault;            // RULE_03
		raw_df[BIT_D1A] = diode1_chan_a_fault;            // RULE_04
		raw_df[BIT_D2A] = diode2_chan_a_fault;            // RULE_04
		raw_df[BIT_FUSEA] = legacy_regulator_mode
			& ~st_r.fuse_s2[0];                           // RULE_05
		raw_df[BIT_FUSEB] = legacy_regulator_mode
			& ~st_r.fuse_s2[1];                           // RULE_05
		raw_df[BIT_VC1] = cpu1_vcore_mismatch;            // RULE_06
		raw_df[BIT_VC2] = cpu2_vcore_mismatch;            // RULE_07
	end

	assign evt_lo  = window_fault[7:0] & ~mask_lo;        // RULE_01
	assign evt_hi  = window_fault[15:8] & ~mask_hi;       // RULE_02
	assign evt_df  = raw_df & ~mask_df;
	assign evt_thr = bin_evt & ~mask_thr;                 // RULE_09

	// ==========================================================
	// Clear decode: writes of one, and reads in the special mode
	assign clr_lo  = clr_for(OFS_VOLT_LO, reg_addr, reg_wr,
		reg_rd, asf_mode, reg_wdata);                     // RULE_13
	assign clr_hi  = clr_for(OFS_VOLT_HI, reg_addr, reg_wr,
		reg_rd, asf_mode, reg_wdata);                     // RULE_13
	assign clr_df  = clr_for(OFS_DIODE_FUSE, reg_addr, reg_wr,
		reg_rd, asf_mode, reg_wdata);                     // RULE_13
	assign clr_thr = clr_for(OFS_CPU1_THR, reg_addr, reg_wr,
		reg_rd, asf_mode, reg_wdata);                     // RULE_13

	// ==========================================================
	// Status registers and throttle bins
	sticky_status_reg #(.W(8)) u_volt_lo ( // RULE_12
		.clock   (clock),
		.reset_n (reset_n),
		.ce      (ce),
		.evt     (evt_lo),
		.clr     (clr_lo),
		.status  (stat_lo)
	);

	sticky_status_reg #(.W(8)) u_volt_hi (
		.clock   (clock),
		.reset_n (reset_n),
		.ce      (ce),
		.evt     (evt_hi),
		.clr     (clr_hi),
		.status  (stat_hi)
	);

	sticky_status_reg #(.W(8)) u_diode_fuse (
		.clock   (clock),
		.reset_n (reset_n),
		.ce      (ce),
		.evt     (evt_df),
		.clr     (clr_df),
		.status  (stat_df)
	);

	sticky_status_reg #(.W(8)) u_cpu1_thr (
		.clock   (clock),
		.reset_n (reset_n),
		.ce      (ce),
		.evt     (evt_thr),
		.clr     (clr_thr),
		.status  (stat_thr)
	);

	throttle_binner u_binner (
		.clock      (clock),
		.reset_n    (reset_n),
		.ce         (ce),
		.meas_valid (throttle_valid),
		.meas       (throttle_meas),
		.user_limit (throttle_user_limit),
		.bin_evt    (bin_evt)
	);

	// ==========================================================
	// Summary excludes the fixed throttle bins
	assign summary_now = (|stat_lo) | (|stat_hi) | (|stat_df)
		| stat_thr[BIT_OVER_LIMIT];                       // RULE_08 RULE_11

	// Next state: sync, read data, summary and alert
	always_comb begin
		st_nxt = st_r;
		if (ce) begin
			st_nxt.fuse_s1 = {fuse_monitor_in_b_n,
				fuse_monitor_in_a_n};
			st_nxt.fuse_s2 = st_r.fuse_s1;
			if (reg_rd) begin
				if (reg_addr == OFS_VOLT_LO) begin
					st_nxt.rdata = stat_lo;
				end else if (reg_addr == OFS_VOLT_HI) begin
					st_nxt.rdata = stat_hi;
				end else if (reg_addr == OFS_DIODE_FUSE) begin
					st_nxt.rdata = stat_df;
				end else if (reg_addr == OFS_CPU1_THR) begin
					st_nxt.rdata = stat_thr;
				end else begin
					st_nxt.rdata = UNMAPPED_READ;
				end
			end
			st_nxt.summary = summary_now;                 // RULE_11
			st_nxt.alert_n = ~(alert_enable & summary_now); // RULE_11
		end
	end

	// State register; zero at reset, except fuse pins idle high and alert_n high
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st_r <= '{fuse_s1: 2'b11, fuse_s2: 2'b11,
				rdata: STATUS_RESET, summary: 1'b0,
				alert_n: 1'b1};                           // RULE_10
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata          = st_r.rdata;
	assign mgmt_error_summary = st_r.summary;
	assign alert_n            = st_r.alert_n;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	AST_LO_SET: assert property ( // RULE_01
		ce && window_fault[0] && !deep |=> stat_lo[0])
		else $error("input one fault did not set its bit");

	AST_HI_NEVER_MASKED: assert property ( // RULE_02
		ce && window_fault[15] |=> stat_hi[7])
		else $error("input sixteen fault lost while masked");

	AST_DIODE_B_MASKED: assert property ( // RULE_03
		ce && in_s3 && diode_opt_mask_s3[0] && !stat_df[0]
		|=> !stat_df[0])
		else $error("masked diode b fault was latched");

	AST_DIODE_A_SET: assert property ( // RULE_04
		ce && diode1_chan_a_fault && !deep |=> stat_df[6])
		else $error("diode a fault did not set bit six");

	AST_FUSE_LEGACY: assert property ( // RULE_05
		$rose(stat_df[BIT_FUSEA]) |-> $past(legacy_regulator_mode))
		else $error("fuse bit set outside legacy mode");

	AST_VCORE2: assert property ( // RULE_07
		ce && cpu2_vcore_mismatch && !deep |=> stat_df[5])
		else $error("core two mismatch not latched");

	AST_SUMMARY_EXCL: assert property ( // RULE_08
		ce && stat_lo == 8'h00 && stat_hi == 8'h00
		&& stat_df == 8'h00 && !stat_thr[7]
		|=> !mgmt_error_summary)
		else $error("throttle bins raised the summary");

	AST_ALERT: assert property ( // RULE_11
		ce && alert_enable && summary_now
		|=> !alert_n && mgmt_error_summary)
		else $error("alert not raised with summary");

	AST_CLEAR_BLOCKED: assert property ( // RULE_12
		ce && reg_wr && reg_addr == OFS_VOLT_LO && reg_wdata[0]
		&& window_fault[0] && !deep |=> stat_lo[0])
		else $error("live fault was cleared");

	AST_STICKY: assert property ( // RULE_12
		ce && stat_hi[2] && clr_hi[2] == 1'b0 |=> stat_hi[2])
		else $error("status bit dropped without a clear");

	AST_ASF_READ: assert property ( // RULE_13
		ce && reg_rd && reg_addr == OFS_VOLT_LO && asf_mode
		&& deep && !reg_wr |=> stat_lo == 8'h00 ##0
		reg_rdata == $past(stat_lo))
		else $error("read did not clear in special mode");

	AST_FULL_BIN: assert property ( // RULE_09
		(ce && throttle_valid && throttle_meas == THR_FULL && !deep)
		##1 (ce && !deep) |=> stat_thr[6] && stat_thr[0])
		else $error("full throttle bin not set");

	COV_FAULT_CLEAR: cover property (
		stat_lo[0] ##1 clr_lo[0] && ce ##1 !stat_lo[0]);
	COV_ASF_READ: cover property (
		ce && reg_rd && asf_mode && stat_hi != 8'h00);
	COV_ALERT: cover property ($fell(alert_n));
	COV_OVER_LIMIT: cover property ($rose(stat_thr[7]));

endmodule : bmc_error_status_bank

`default_nettype wire

/* hw/status_bank_pkg.sv */
/*
 * Constants for the management error status bank: register offsets,
 * bit positions, sleep-state codes and throttle bin thresholds.
 * Assumes an 8-bit register port and a 9-bit throttle measurement.
 */
package status_bank_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_VOLT_LO    = 8'h41;
	localparam logic [7:0] OFS_VOLT_HI    = 8'h42;
	localparam logic [7:0] OFS_DIODE_FUSE = 8'h43;
	localparam logic [7:0] OFS_CPU1_THR   = 8'h44;
	localparam logic [7:0] STATUS_RESET   = 8'h00;
	localparam logic [7:0] UNMAPPED_READ  = 8'h00;

	// ==========================================================
	// Bit positions in the diode, fuse and core-voltage register
	localparam int BIT_D1B   = 0;
	localparam int BIT_D2B   = 1;
	localparam int BIT_FUSEA = 2;
	localparam int BIT_FUSEB = 3;
	localparam int BIT_VC1   = 4;
	localparam int BIT_VC2   = 5;
	localparam int BIT_D1A   = 6;
	localparam int BIT_D2A   = 7;

	// Bit position of the over-limit flag in the throttle register
	localparam int BIT_OVER_LIMIT = 7;

	// ==========================================================
	// Sleep-state codes
	typedef enum logic [1:0] {
		SLEEP_S0  = 2'b00,
		SLEEP_S1  = 2'b01,
		SLEEP_S3  = 2'b10,
		SLEEP_S45 = 2'b11
	} sleep_state_t;

	// ==========================================================
	// Throttle scale: full throttle reads as this count
	localparam int          THR_W     = 9;
	localparam logic [8:0]  THR_FULL  = 9'h100;
	localparam logic [8:0]  THR_12P5  = 9'h020;
	localparam logic [8:0]  THR_25    = 9'h040;
	localparam logic [8:0]  THR_50    = 9'h080;
	localparam logic [8:0]  THR_75    = 9'h0C0;
	localparam logic [8:0]  THR_ZERO  = 9'h000;

endpackage : status_bank_pkg

/* hw/sticky_status_reg.sv */
/*
 * One sticky status register: event bits set, clear bits clear, set
 * wins over clear in the same cycle.
 * Assumes events are already masked and clears already decoded.
 */
`timescale 1ns/10ps
`default_nettype none

module sticky_status_reg
	import status_bank_pkg::*;
#(
	parameter int W = 8
) (
	// Clock, reset, enable
	input  wire logic         clock,
	input  wire logic         reset_n,
	input  wire logic         ce,
	// Set and clear strobes
	input  wire logic [W-1:0] evt,
	input  wire logic [W-1:0] clr,
	// Status bits
	output logic      [W-1:0] status
);

	typedef struct packed {
		logic [W-1:0] bits;
	} sticky_state_t;

	sticky_state_t st_r;
	sticky_state_t st_nxt;

	// ==========================================================
	// Next state: clear first, then set so a live event survives
	always_comb begin
		st_nxt = st_r;
		if (ce) begin
			st_nxt.bits = (st_r.bits & ~clr) | evt;
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st_r <= '{bits: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign status = st_r.bits;

endmodule : sticky_status_reg

`default_nettype wire

/* hw/throttle_binner.sv */
/*
 * Sorts each nonzero throttle measurement into range bins and flags levels
 * above the user limit; one-cycle event pulses, registered.
 * Assumes a same-clock measurement strobe; 256 counts = 100 percent.
 */
`timescale 1ns/10ps
`default_nettype none

module throttle_binner
	import status_bank_pkg::*;
(
	// Clock, reset, enable
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic             ce,
	// Measurement
	input  wire logic             meas_valid,
	input  wire logic [THR_W-1:0] meas,
	input  wire logic [THR_W-1:0] user_limit,
	// Bin events
	output logic      [7:0]       bin_evt
);

	typedef struct packed {
		logic [7:0] evt;
	} bin_state_t;

	bin_state_t st_r;
	bin_state_t st_nxt;

	// ==========================================================
	// Bin decode of one measurement
	always_comb begin
		st_nxt = st_r;
		if (ce) begin
			st_nxt.evt = 8'h00;
			if (meas_valid && meas != THR_ZERO) begin
				st_nxt.evt[0] = 1'b1;
				st_nxt.evt[1] = meas < THR_12P5;
				st_nxt.evt[2] = meas >= THR_12P5 && meas < THR_25;
				st_nxt.evt[3] = meas >= THR_25 && meas < THR_50;
				st_nxt.evt[4] = meas >= THR_50 && meas < THR_75;
				st_nxt.evt[5] = meas >= THR_75 && meas < THR_FULL;
				st_nxt.evt[6] = meas >= THR_FULL;
				st_nxt.evt[BIT_OVER_LIMIT] = meas > user_limit;
			end
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st_r <= '{evt: 8'h00};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bin_evt = st_r.evt;

endmodule : throttle_binner

`default_nettype wire

/* bench/host_model.sv */
/*
 * Host side of the status bank: a management controller model that
 * issues one-cycle read and write strobes on the register port.
 * Assumes the bank answers one edge after the strobe is taken.
 */
`timescale 1ns/10ps
`default_nettype none

module host_model (
	// Clock
	input  wire logic       clock,
	// Register port
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	// ==========================================================
	// Idle port values
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_wdata = 8'h00;
	end

	// One access; ones in d clear bits on a write
	task automatic access(input logic [7:0] a, input logic w,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clock);
		reg_addr = a;
		reg_wr = w;
		reg_rd = ~w;
		reg_wdata = d;
		@(negedge clock);
		q = reg_rdata;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = ~a; // Stale bus, not last value
		reg_wdata = ~d;
	endtask : access
endmodule : host_model

`default_nettype wire

/* bench/tb_top.sv */
/*
 * Testbench for the management error status bank: scenario tasks for
 * reset, masking, clearing, diode/fuse/core and throttle bits.
 * Assumes the host model drives the register port.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top import status_bank_pkg::*;;
	// ==========================================================
	// Stimulus and wiring
	logic             clock = 1'h0;
	logic             reset_n = 1'h0;
	logic             ce = 1'h1;
	logic             asf_mode = 1'h0;
	logic             alert_enable = 1'h1;
	logic             legacy_regulator_mode = 1'h0;
	logic [1:0]       sleep_state = SLEEP_S0;
	logic [2:0]       hi_opt_mask_s3 = 3'h5;
	logic [2:0]       hi_opt_mask_s45 = 3'h2;
	logic [3:0]       diode_opt_mask_s3 = 4'h5;
	logic [3:0]       diode_opt_mask_s45 = 4'hA;
	logic [15:0]      window_fault = 16'h0000;
	logic [3:0]       diode_f = 4'h0;
	logic [1:0]       fuse_n = 2'h3;
	logic [1:0]       vcore = 2'h0;
	logic             throttle_valid = 1'h0;
	logic [THR_W-1:0] throttle_meas = THR_ZERO;
	logic [THR_W-1:0] throttle_user_limit = THR_FULL;
	wire logic [7:0]  reg_addr;
	wire logic        reg_wr;
	wire logic        reg_rd;
	wire logic [7:0]  reg_wdata;
	wire logic [7:0]  reg_rdata;
	wire logic        mgmt_error_summary;
	wire logic        alert_n;
	int               failures = 0;
	int               tests_run = 0;

	always #50 clock = ~clock;

	host_model host (.clock, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata);

	bmc_error_status_bank dut (.clock, .reset_n, .ce, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata, .asf_mode, .alert_enable,
		.legacy_regulator_mode, .sleep_state, .hi_opt_mask_s3,
		.hi_opt_mask_s45, .diode_opt_mask_s3, .diode_opt_mask_s45,
		.window_fault, .diode1_chan_b_fault(diode_f[0]),
		.diode2_chan_b_fault(diode_f[1]), .diode1_chan_a_fault(diode_f[2]),
		.diode2_chan_a_fault(diode_f[3]), .fuse_monitor_in_a_n(fuse_n[0]),
		.fuse_monitor_in_b_n(fuse_n[1]), .cpu1_vcore_mismatch(vcore[0]),
		.cpu2_vcore_mismatch(vcore[1]), .throttle_valid, .throttle_meas,
		.throttle_user_limit, .mgmt_error_summary, .alert_n);

	// ==========================================================
	// Shared helpers
	task automatic check(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		host.access(a, 1'h0, 8'h00, q);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.access(a, 1'h1, d, q);
	endtask : wr

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	// ==========================================================
	// Scenarios
	task automatic test_reset();
		logic [7:0] q;
		for (int i = 0; i < 5; i++) begin
			rd(8'h40 + 8'(i), q);
			check(q, STATUS_RESET, "reset value");
		end
		check({7'h00, alert_n}, 8'h01, "alert idle");
		$display("test_reset done");
	endtask : test_reset

	task automatic test_window();
		logic [7:0] q;
		window_fault = 16'h00A5;
		cyc(1);
		window_fault = 16'h0000;
		cyc(2);
		check({7'h00, mgmt_error_summary}, 8'h01, "summary");
		check({7'h00, alert_n}, 8'h00, "alert on");
		alert_enable = 1'h0;
		cyc(2);
		check({7'h00, alert_n}, 8'h01, "alert gated");
		alert_enable = 1'h1;
		wr(OFS_VOLT_LO, 8'h00);
		rd(OFS_VOLT_LO, q);
		check(q, 8'hA5, "zero write");
		wr(OFS_VOLT_LO, 8'h05);
		rd(OFS_VOLT_LO, q);
		check(q, 8'hA0, "partial clear");
		wr(OFS_VOLT_LO, 8'hFF);
		cyc(2);
		check({7'h00, mgmt_error_summary}, 8'h00, "summary drop");
		$display("test_window done");
	endtask : test_window

	task automatic test_sleep();
		logic [1:0] st [4] = '{SLEEP_S0, SLEEP_S1, SLEEP_S3, SLEEP_S45};
		logic [7:0] lo [4] = '{8'hFF, 8'hFF, 8'h00, 8'h00};
		logic [7:0] hi [4] = '{8'hFF, 8'hFF, 8'h90, 8'hA8};
		logic [7:0] q;
		for (int i = 0; i < 4; i++) begin
			sleep_state = st[i];
			window_fault = 16'hFFFF;
			cyc(1);
			window_fault = 16'h0000;
			sleep_state = SLEEP_S0;
			rd(OFS_VOLT_LO, q);
			check(q, lo[i], "low bank");
			rd(OFS_VOLT_HI, q);
			check(q, hi[i], "high bank");
			wr(OFS_VOLT_LO, 8'hFF);
			wr(OFS_VOLT_HI, 8'hFF);
		end
		$display("test_sleep done");
	endtask : test_sleep

	task automatic test_diode();
		logic [1:0] st [4] = '{SLEEP_S0, SLEEP_S0, SLEEP_S3, SLEEP_S45};
		logic       lg [4] = '{1'h1, 1'h0, 1'h1, 1'h1};
		logic [7:0] ex [4] = '{8'hFF, 8'hF3, 8'h82, 8'h41};
		logic [7:0] q;
		for (int i = 0; i < 4; i++) begin
			sleep_state = st[i];
			legacy_regulator_mode = lg[i];
			diode_f = 4'hF;
			fuse_n = 2'h0;
			vcore = 2'h3;
			cyc(4);
			diode_f = 4'h0;
			fuse_n = 2'h3;
			vcore = 2'h0;
			cyc(3);
			sleep_state = SLEEP_S0;
			rd(OFS_DIODE_FUSE, q);
			check(q, ex[i], "diode fuse core");
			wr(OFS_DIODE_FUSE, 8'hFF);
		end
		$display("test_diode done");
	endtask : test_diode

	task automatic test_clear();
		logic [7:0] q;
		window_fault = 16'h0001;
		cyc(1);
		wr(OFS_VOLT_LO, 8'h01);
		rd(OFS_VOLT_LO, q);
		check(q, 8'h01, "live clear");
		sleep_state = SLEEP_S3;
		wr(OFS_VOLT_LO, 8'h01);
		rd(OFS_VOLT_LO, q);
		check(q, 8'h00, "masked clear");
		window_fault = 16'h0000;
		sleep_state = SLEEP_S0;
		$display("test_clear done");
	endtask : test_clear

	task automatic test_asf();
		logic [7:0] q;
		window_fault = 16'h0004;
		cyc(1);
		window_fault = 16'h0000;
		rd(OFS_VOLT_LO, q);
		rd(OFS_VOLT_LO, q);
		check(q, 8'h04, "plain read keeps");
		asf_mode = 1'h1;
		sleep_state = SLEEP_S3;
		rd(OFS_VOLT_LO, q);
		check(q, 8'h04, "asf first read");
		rd(OFS_VOLT_LO, q);
		check(q, 8'h00, "asf read clears");
		asf_mode = 1'h0;
		sleep_state = SLEEP_S0;
		$display("test_asf done");
	endtask : test_asf

	task automatic test_throttle();
		logic [8:0] ms [8] = '{9'h001, 9'h020, 9'h040, 9'h080, 9'h0C0,
			9'h100, 9'h000, 9'h01F};
		logic [7:0] ex [8] = '{8'h03, 8'h05, 8'h09, 8'h11, 8'h21, 8'h41,
			8'h00, 8'h83};
		logic [7:0] q;
		for (int i = 0; i < 8; i++) begin
			throttle_user_limit = (i == 7) ? 9'h01E : THR_FULL;
			throttle_meas = ms[i];
			throttle_valid = 1'h1;
			cyc(1);
			throttle_valid = 1'h0;
			cyc(2);
			check({7'h00, mgmt_error_summary}, {7'h00, ex[i][7]}, "bins");
			rd(OFS_CPU1_THR, q);
			check(q, ex[i], "throttle bins");
			wr(OFS_CPU1_THR, 8'hFF);
		end
		$display("test_throttle done");
	endtask : test_throttle

	// Enable low: a live fault must not reach the bank
	task automatic test_hold();
		logic [7:0] q;
		ce = 1'h0;
		window_fault = 16'h0010;
		cyc(2);
		window_fault = 16'h0000;
		ce = 1'h1;
		rd(OFS_VOLT_LO, q);
		check(q, 8'h00, "frozen by enable");
		$display("test_hold done");
	endtask : test_hold

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		cyc(6);
		reset_n = 1'h1;
		cyc(1);
		test_reset();
		test_window();
		test_sleep();
		test_diode();
		test_clear();
		test_asf();
		test_hold();
		test_throttle();
		close_out();
	end

	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		close_out();
	end
endmodule : tb_top

`default_nettype wire
